/* design/tdlr_pkg.sv */
// Purpose: shared constants and types of the temperature reading and limit register bank
// Assumes: 32-bit APB data, one register per aligned word, byte address is four times the index
// Notes: readings are 11-bit two's complement, eighth-degree steps; limits keep the upper eight bits

package tdlr_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int READING_W = 11;
	localparam int LIMIT_W = 8;
	localparam int FRAC_W = 3;
	localparam int PASSIVE_W = 6;
	localparam int IDX_W = 8;
	localparam int DATA_W = 32;
	localparam int IDX_LSB = 2;
	localparam int CHANNELS = 2;
	localparam int CH_LOCAL = 0;
	localparam int CH_REMOTE = 1;

	// ----------------------------------------------------------------
	// register indices, byte address is index times four
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_SHARED_LOW = 8'h06;
	localparam logic [7:0] IDX_LOCAL_UPPER = 8'h0a;
	localparam logic [7:0] IDX_REMOTE_UPPER = 8'h0b;
	localparam logic [7:0] IDX_LOCAL_HIGH = 8'h14;
	localparam logic [7:0] IDX_LOCAL_LOW = 8'h15;
	localparam logic [7:0] IDX_LOCAL_THERMAL = 8'h16;
	localparam logic [7:0] IDX_REMOTE_HIGH = 8'h18;
	localparam logic [7:0] IDX_REMOTE_LOW = 8'h19;
	localparam logic [7:0] IDX_REMOTE_THERMAL = 8'h1a;
	localparam logic [7:0] IDX_LOCAL_CRITICAL = 8'h1b;
	localparam logic [7:0] IDX_PASSIVE = 8'h1c;
	localparam logic [7:0] IDX_REMOTE_CRITICAL = 8'h1d;
	localparam logic [7:0] IDX_STATUS = 8'h20;

	// ----------------------------------------------------------------
	// values after reset
	// ----------------------------------------------------------------
	localparam logic [10:0] RST_READING = 11'h400;
	localparam logic [7:0] RST_LOCAL_HIGH = 8'h3c;
	localparam logic [7:0] RST_LOCAL_LOW = 8'h00;
	localparam logic [7:0] RST_LOCAL_THERMAL = 8'h46;
	localparam logic [7:0] RST_LOCAL_CRITICAL = 8'h50;
	localparam logic [7:0] RST_REMOTE_HIGH = 8'h50;
	localparam logic [7:0] RST_REMOTE_LOW = 8'h00;
	localparam logic [7:0] RST_REMOTE_THERMAL = 8'h64;
	localparam logic [7:0] RST_REMOTE_CRITICAL = 8'h69;
	localparam logic [5:0] RST_PASSIVE = 6'h00;
	localparam logic [7:0] RST_DUTY = 8'h00;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
		logic [7:0] thermal;
		logic [7:0] critical;
	} tdlr_limits_t;

	typedef struct packed {
		logic [7:0] idx;
		logic mapped_word;
		logic write;
		logic lane0;
		logic [31:0] wdata;
	} tdlr_req_t;

	typedef enum logic [0:0] {
		TDLR_IDLE = 1'b0,
		TDLR_ACK = 1'b1
	} tdlr_apb_state_t;

endpackage

/* design/tdlr_freeze.sv */
// Purpose: holds the readings that software sees and freezes them for two-byte reads
// Assumes: live results and their strobe come from logic on the same clock
// Notes: a result that arrives while frozen is parked and shown once the freeze ends

`timescale 1ns/100ps

module tdlr_freeze (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [tdlr_pkg::CHANNELS-1:0][tdlr_pkg::READING_W-1:0] i_live,
	input wire logic i_live_valid,
	input wire logic i_freeze_req,
	input wire logic i_release_req,
	output logic [tdlr_pkg::CHANNELS-1:0][tdlr_pkg::READING_W-1:0] o_shown,
	output logic o_frozen
);

	logic hold;

	// the freezing edge itself must not move the readings just returned
	assign hold = (o_frozen & ~i_release_req) | i_freeze_req; // see (RULE_05)

	// freeze flag, set by the low-byte read, cleared by the remote upper read
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_frozen <= 1'b0;
		end else if (i_freeze_req) begin
			o_frozen <= 1'b1; // see (RULE_05)
		end else if (i_release_req) begin
			o_frozen <= 1'b0;
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < tdlr_pkg::CHANNELS; ch++) begin : g_ch
			logic [tdlr_pkg::READING_W-1:0] park_r;
			logic park_valid_r;

			// park the newest result while frozen; a new one beats the drain
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					park_r <= tdlr_pkg::RST_READING;
					park_valid_r <= 1'b0;
				end else if (i_live_valid && hold) begin
					park_r <= i_live[ch];
					park_valid_r <= 1'b1;
				end else if (!hold) begin
					park_valid_r <= 1'b0;
				end
			end

			// upper and lower bits move only together, never during a freeze
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					o_shown[ch] <= tdlr_pkg::RST_READING; // see (RULE_02)
				end else if (!hold && i_live_valid) begin
					o_shown[ch] <= i_live[ch]; // see (RULE_06)
				end else if (!hold && park_valid_r) begin
					o_shown[ch] <= park_r; // see (RULE_06)
				end
			end
		end
	endgenerate

endmodule

/* design/tdlr_top.sv */
// Purpose: APB register bank for temperature readings, limits and passive fan cooling
// Assumes: conversion results, duty request and active temperature come from the same clock
// Notes: one wait state on every APB access; read side effects fire when read data is latched
//
// How it works
// (RULE_01) remote upper register shows reading bits ten to three, bit ten on top.
// (RULE_02) the remote upper register reads 0x80 after reset, minus 128 degrees.
// (RULE_03) readings come as 8-bit whole degrees or 11-bit eighth degrees with low byte.
// (RULE_04) upper registers read alone, in any order, always return valid readings.
// (RULE_05) reading the low byte first freezes all readings until the remote upper read.
// (RULE_06) frozen readings keep upper and lower bits together while both are fetched.
// (RULE_07) every limit is 11 bits, low three zero, so one byte is stored.
// (RULE_08) local limits reset to 0x3c, 0x00, 0x46 and 0x50.
// (RULE_09) remote limits reset to 0x50, 0x00, 0x64 and 0x69.
// (RULE_10) passive threshold stores bits eight to three only, range zero to 63 degrees.
// (RULE_11) in automatic mode duty is forced to zero at or below passive threshold.
// (RULE_12) local and remote each own high, low, thermal and critical registers.
// (RULE_13) shared low byte holds local low bits at 7:5, remote at 2:0.
// (RULE_14) fixed-zero limit bits ignore writes and always read back as zero.
//
// The APB slave port was decided locally.

`timescale 1ns/100ps

module tdlr_top #(
	parameter int ADDR_W = 12
) (
	input wire logic I_CLK,
	input wire logic I_RST_N,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [ADDR_W-1:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic [3:0] I_PSTRB,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	input wire logic [tdlr_pkg::READING_W-1:0] I_LOCAL_TEMP,
	input wire logic [tdlr_pkg::READING_W-1:0] I_REMOTE_TEMP,
	input wire logic I_TEMP_VALID,
	input wire logic I_AUTO_TEMP_MODE,
	input wire logic [tdlr_pkg::READING_W-1:0] I_ACTIVE_TEMP,
	input wire logic [7:0] I_DUTY_REQ,
	output logic [7:0] O_DUTY,
	output logic O_FAN_STOPPED,
	output tdlr_pkg::tdlr_limits_t O_LOCAL_LIMITS,
	output tdlr_pkg::tdlr_limits_t O_REMOTE_LIMITS,
	output logic [tdlr_pkg::PASSIVE_W-1:0] O_PASSIVE_BITS,
	output logic O_READINGS_FROZEN
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------

	// the eight-bit index field needs ten byte-address bits
	generate
		if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr_w
			$error("tdlr_top: ADDR_W must lie between 10 and 32");
		end
	endgenerate

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	tdlr_pkg::tdlr_apb_state_t state_r;
	tdlr_pkg::tdlr_apb_state_t state_nxt;
	tdlr_pkg::tdlr_req_t req;
	logic setup_seen;
	logic commit_wr;
	logic capture_rd;
	logic freeze_req;
	logic release_req;
	logic [31:0] rd_data_nxt;
	logic rd_err_nxt;
	logic [tdlr_pkg::CHANNELS-1:0][tdlr_pkg::READING_W-1:0] live;
	logic [tdlr_pkg::CHANNELS-1:0][tdlr_pkg::READING_W-1:0] shown;
	logic [tdlr_pkg::READING_W-1:0] local_shown;
	logic [tdlr_pkg::READING_W-1:0] remote_shown;
	logic [7:0] shared_reading_low_byte;
	logic [tdlr_pkg::READING_W-1:0] passive_threshold;
	logic fan_stop_nxt;
	logic [7:0] wr_byte;

	// ----------------------------------------------------------------
	// request decode
	// ----------------------------------------------------------------

	// misaligned or out-of-range addresses land on no register
	always_comb begin
		req.idx = I_PADDR[9:2];
		req.mapped_word = (I_PADDR[1:0] == 2'b00) && ((I_PADDR >> 10) == '0);
		req.write = I_PWRITE;
		req.lane0 = I_PSTRB[0];
		req.wdata = I_PWDATA;
	end

	assign wr_byte = req.wdata[7:0];

	// ----------------------------------------------------------------
	// apb handshake
	// ----------------------------------------------------------------

	// one wait state keeps pready, prdata and pslverr straight from flops
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			tdlr_pkg::TDLR_IDLE: begin
				if (I_PSEL && I_PENABLE) begin
					state_nxt = tdlr_pkg::TDLR_ACK;
				end
			end
			tdlr_pkg::TDLR_ACK: begin
				state_nxt = tdlr_pkg::TDLR_IDLE;
			end
			default: begin
				state_nxt = tdlr_pkg::TDLR_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state_r <= tdlr_pkg::TDLR_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// first access cycle latches read data; the master cannot withdraw after it
	assign setup_seen = (state_r == tdlr_pkg::TDLR_IDLE) && I_PSEL && I_PENABLE;
	// writes land on the edge that samples pready high
	assign commit_wr = (state_r == tdlr_pkg::TDLR_ACK) && I_PSEL && I_PENABLE && req.write
		&& req.mapped_word && req.lane0;
	assign capture_rd = setup_seen && !req.write && req.mapped_word;

	// pready pulses for one cycle in the second access cycle
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_PREADY <= 1'b0;
		end else begin
			O_PREADY <= (state_nxt == tdlr_pkg::TDLR_ACK);
		end
	end

	// read data and error stand only during the ready cycle
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_PRDATA <= 32'h0000_0000;
			O_PSLVERR <= 1'b0;
		end else if (setup_seen) begin
			O_PRDATA <= (req.write || rd_err_nxt) ? 32'h0000_0000 : rd_data_nxt; // refused reads return zero
			O_PSLVERR <= rd_err_nxt;
		end else begin
			O_PRDATA <= 32'h0000_0000;
			O_PSLVERR <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// readings and freeze
	// ----------------------------------------------------------------

	// low-byte read freezes, remote upper read releases
	assign freeze_req = capture_rd && (req.idx == tdlr_pkg::IDX_SHARED_LOW); // see (RULE_05)
	assign release_req = capture_rd && (req.idx == tdlr_pkg::IDX_REMOTE_UPPER); // see (RULE_05)

	assign live[tdlr_pkg::CH_LOCAL] = I_LOCAL_TEMP;
	assign live[tdlr_pkg::CH_REMOTE] = I_REMOTE_TEMP;

	// snapshot keeper; upper-byte reads alone never touch it
	tdlr_freeze u_freeze (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_live(live),
		.i_live_valid(I_TEMP_VALID),
		.i_freeze_req(freeze_req),
		.i_release_req(release_req),
		.o_shown(shown),
		.o_frozen(O_READINGS_FROZEN)
	); // see (RULE_04)

	assign local_shown = shown[tdlr_pkg::CH_LOCAL];
	assign remote_shown = shown[tdlr_pkg::CH_REMOTE];

	// local low bits on top, two zero bits, remote low bits below
	assign shared_reading_low_byte = {local_shown[tdlr_pkg::FRAC_W-1:0], 2'b00,
		remote_shown[tdlr_pkg::FRAC_W-1:0]}; // see (RULE_13)

	// ----------------------------------------------------------------
	// read multiplexer
	// ----------------------------------------------------------------

	// byte data sits in the low lane, upper bits read as zero
	always_comb begin
		rd_data_nxt = 32'h0000_0000;
		rd_err_nxt = !req.mapped_word;
		case (req.idx)
			tdlr_pkg::IDX_SHARED_LOW: begin
				rd_data_nxt[7:0] = shared_reading_low_byte; // see (RULE_03)
			end
			tdlr_pkg::IDX_LOCAL_UPPER: begin
				rd_data_nxt[7:0] = local_shown[10:3];
			end
			tdlr_pkg::IDX_REMOTE_UPPER: begin
				rd_data_nxt[7:0] = remote_shown[10:3]; // see (RULE_01)
			end
			tdlr_pkg::IDX_LOCAL_HIGH: begin
				rd_data_nxt[7:0] = O_LOCAL_LIMITS.high;
			end
			tdlr_pkg::IDX_LOCAL_LOW: begin
				rd_data_nxt[7:0] = O_LOCAL_LIMITS.low;
			end
			tdlr_pkg::IDX_LOCAL_THERMAL: begin
				rd_data_nxt[7:0] = O_LOCAL_LIMITS.thermal;
			end
			tdlr_pkg::IDX_LOCAL_CRITICAL: begin
				rd_data_nxt[7:0] = O_LOCAL_LIMITS.critical;
			end
			tdlr_pkg::IDX_REMOTE_HIGH: begin
				rd_data_nxt[7:0] = O_REMOTE_LIMITS.high;
			end
			tdlr_pkg::IDX_REMOTE_LOW: begin
				rd_data_nxt[7:0] = O_REMOTE_LIMITS.low;
			end
			tdlr_pkg::IDX_REMOTE_THERMAL: begin
				rd_data_nxt[7:0] = O_REMOTE_LIMITS.thermal;
			end
			tdlr_pkg::IDX_REMOTE_CRITICAL: begin
				rd_data_nxt[7:0] = O_REMOTE_LIMITS.critical;
			end
			tdlr_pkg::IDX_PASSIVE: begin
				rd_data_nxt[7:0] = {2'b00, O_PASSIVE_BITS}; // see (RULE_14)
			end
			tdlr_pkg::IDX_STATUS: begin
				rd_data_nxt[1:0] = {O_FAN_STOPPED, O_READINGS_FROZEN};
			end
			default: begin
				rd_err_nxt = 1'b1;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// local limit registers
	// ----------------------------------------------------------------

	// one byte per limit; the three implied low bits are never stored
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_LOCAL_LIMITS.high <= tdlr_pkg::RST_LOCAL_HIGH; // see (RULE_08)
			O_LOCAL_LIMITS.low <= tdlr_pkg::RST_LOCAL_LOW;
			O_LOCAL_LIMITS.thermal <= tdlr_pkg::RST_LOCAL_THERMAL;
			O_LOCAL_LIMITS.critical <= tdlr_pkg::RST_LOCAL_CRITICAL;
		end else if (commit_wr) begin
			case (req.idx)
				tdlr_pkg::IDX_LOCAL_HIGH: begin
					O_LOCAL_LIMITS.high <= wr_byte; // see (RULE_07)
				end
				tdlr_pkg::IDX_LOCAL_LOW: begin
					O_LOCAL_LIMITS.low <= wr_byte; // see (RULE_12)
				end
				tdlr_pkg::IDX_LOCAL_THERMAL: begin
					O_LOCAL_LIMITS.thermal <= wr_byte;
				end
				tdlr_pkg::IDX_LOCAL_CRITICAL: begin
					O_LOCAL_LIMITS.critical <= wr_byte;
				end
				default: begin
					O_LOCAL_LIMITS <= O_LOCAL_LIMITS;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// remote limit registers
	// ----------------------------------------------------------------

	// separate set so either sensor can be retuned alone
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_REMOTE_LIMITS.high <= tdlr_pkg::RST_REMOTE_HIGH; // see (RULE_09)
			O_REMOTE_LIMITS.low <= tdlr_pkg::RST_REMOTE_LOW;
			O_REMOTE_LIMITS.thermal <= tdlr_pkg::RST_REMOTE_THERMAL;
			O_REMOTE_LIMITS.critical <= tdlr_pkg::RST_REMOTE_CRITICAL;
		end else if (commit_wr) begin
			case (req.idx)
				tdlr_pkg::IDX_REMOTE_HIGH: begin
					O_REMOTE_LIMITS.high <= wr_byte; // see (RULE_12)
				end
				tdlr_pkg::IDX_REMOTE_LOW: begin
					O_REMOTE_LIMITS.low <= wr_byte;
				end
				tdlr_pkg::IDX_REMOTE_THERMAL: begin
					O_REMOTE_LIMITS.thermal <= wr_byte;
				end
				tdlr_pkg::IDX_REMOTE_CRITICAL: begin
					O_REMOTE_LIMITS.critical <= wr_byte; // see (RULE_07)
				end
				default: begin
					O_REMOTE_LIMITS <= O_REMOTE_LIMITS;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// passive cooling threshold
	// ----------------------------------------------------------------

	// only six bits exist, so writes to the top two are dropped
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_PASSIVE_BITS <= tdlr_pkg::RST_PASSIVE;
		end else if (commit_wr && req.idx == tdlr_pkg::IDX_PASSIVE) begin
			O_PASSIVE_BITS <= wr_byte[5:0]; // see (RULE_10) see (RULE_14)
		end
	end

	// rebuild the 11-bit threshold; it cannot exceed 63 degrees
	assign passive_threshold = {2'b00, O_PASSIVE_BITS, 3'b000}; // see (RULE_10)

	// ----------------------------------------------------------------
	// fan duty gate
	// ----------------------------------------------------------------

	// signed compare, so readings below zero also stop the fan
	assign fan_stop_nxt = I_AUTO_TEMP_MODE
		&& ($signed(I_ACTIVE_TEMP) <= $signed(passive_threshold)); // see (RULE_11)

	// one cycle of latency trades for a clean registered fan output
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_DUTY <= tdlr_pkg::RST_DUTY;
			O_FAN_STOPPED <= 1'b0;
		end else begin
			O_DUTY <= fan_stop_nxt ? tdlr_pkg::RST_DUTY : I_DUTY_REQ; // see (RULE_11)
			O_FAN_STOPPED <= fan_stop_nxt;
		end
	end

endmodule

/* bench/tdlr_monitor.sv */
// Purpose: port checks of the register bank
// Assumes: one wait state per access
// Notes: bound to every bank instance
`timescale 1ns/100ps
module tdlr_monitor #(
	parameter int ADDR_W = 12
) (
	input wire logic I_CLK,
	input wire logic I_RST_N,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [ADDR_W-1:0] I_PADDR,
	input wire logic [31:0] O_PRDATA,
	input wire logic O_PREADY,
	input wire logic O_PSLVERR,
	input wire logic I_AUTO_TEMP_MODE,
	input wire logic [tdlr_pkg::READING_W-1:0] I_ACTIVE_TEMP,
	input wire logic [7:0] I_DUTY_REQ,
	input wire logic [7:0] O_DUTY,
	input wire logic O_FAN_STOPPED,
	input wire tdlr_pkg::tdlr_limits_t O_LOCAL_LIMITS,
	input wire tdlr_pkg::tdlr_limits_t O_REMOTE_LIMITS,
	input wire logic [tdlr_pkg::PASSIVE_W-1:0] O_PASSIVE_BITS,
	input wire logic O_READINGS_FROZEN
);
	// ----------------------------------------------------------------
	// helper terms
	// ----------------------------------------------------------------
	logic acc_c;
	logic wr_c;
	logic stop_c;
	logic rel_c;
	assign acc_c = I_PSEL & I_PENABLE & !O_PREADY;
	assign wr_c = I_PSEL & I_PENABLE & I_PWRITE & O_PREADY;
	assign rel_c = acc_c & !I_PWRITE & (I_PADDR == 12'h02c);
	// threshold low bits are zero, compare is signed so negatives stop the fan
	assign stop_c = I_AUTO_TEMP_MODE && ($signed(I_ACTIVE_TEMP) <= $signed({2'b00, O_PASSIVE_BITS, 3'b000}));
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	ready_pulse_a: assert property (O_PREADY |=> !O_PREADY) else $error("pready longer than one cycle");
	ready_delay_a: assert property (acc_c |=> O_PREADY) else $error("pready late");
	rdata_idle_a: assert property (!O_PREADY |-> O_PRDATA == 32'h0) else $error("rdata outside answer");
	err_clean_a: assert property (O_PSLVERR |-> O_PREADY && O_PRDATA == 32'h0) else $error("bad error answer");
	freeze_set_a: assert property (acc_c && !I_PWRITE && I_PADDR == 12'h018 |=> O_READINGS_FROZEN)
		else $error("low byte read did not freeze");
	freeze_end_a: assert property (rel_c |=> !O_READINGS_FROZEN) else $error("remote upper read kept freeze");
	freeze_hold_a: assert property (O_READINGS_FROZEN && !rel_c |=> O_READINGS_FROZEN)
		else $error("freeze dropped early");
	fan_gate_a: assert property ($past(I_RST_N) |-> O_FAN_STOPPED == $past(stop_c)) else $error("fan stop wrong");
	duty_gate_a: assert property ($past(I_RST_N) |-> O_DUTY == ($past(stop_c) ? 8'h00 : $past(I_DUTY_REQ)))
		else $error("duty wrong");
	limits_hold_a: assert property (!$past(wr_c) |-> $stable(O_LOCAL_LIMITS) && $stable(O_REMOTE_LIMITS)
		&& $stable(O_PASSIVE_BITS)) else $error("limit changed without write");
	cover property (rel_c && O_READINGS_FROZEN);
	cover property (O_FAN_STOPPED);
	cover property (O_PSLVERR);
endmodule
bind tdlr_top tdlr_monitor #(.ADDR_W(ADDR_W)) mon (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_PSEL(I_PSEL),
	.I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
	.O_PSLVERR(O_PSLVERR), .I_AUTO_TEMP_MODE(I_AUTO_TEMP_MODE), .I_ACTIVE_TEMP(I_ACTIVE_TEMP),
	.I_DUTY_REQ(I_DUTY_REQ), .O_DUTY(O_DUTY), .O_FAN_STOPPED(O_FAN_STOPPED), .O_LOCAL_LIMITS(O_LOCAL_LIMITS),
	.O_REMOTE_LIMITS(O_REMOTE_LIMITS), .O_PASSIVE_BITS(O_PASSIVE_BITS), .O_READINGS_FROZEN(O_READINGS_FROZEN));

/* bench/tdlr_host.sv */
// Purpose: host side, an APB master
// Assumes: xfer is entered just after a rising edge
// Notes: waits for pready with no cycle count of its own
`timescale 1ns/100ps
module tdlr_host (
	input wire logic i_clk,
	input wire logic [31:0] i_prdata,
	input wire logic i_pready,
	input wire logic i_pslverr,
	output logic o_psel,
	output logic o_penable,
	output logic o_pwrite,
	output logic [11:0] o_paddr,
	output logic [31:0] o_pwdata,
	output logic [3:0] o_pstrb
);
	initial begin
		o_psel = 1'b0;
		o_penable = 1'b0;
		o_pwrite = 1'b0;
		o_paddr = 12'h000;
		o_pwdata = 32'h0;
		o_pstrb = 4'h0;
	end
	// one transfer; request held until pready seen at an edge
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] rd, output logic er);
		o_psel <= 1'b1;
		o_pwrite <= w;
		o_paddr <= a;
		o_pwdata <= d;
		o_pstrb <= s;
		@(posedge i_clk);
		o_penable <= 1'b1;
		do @(posedge i_clk); while (i_pready !== 1'b1);
		rd = i_prdata;
		er = i_pslverr;
		o_psel <= 1'b0;
		o_penable <= 1'b0;
		// idle cycle so the next call never assigns twice in one step
		@(posedge i_clk);
	endtask
endmodule

/* bench/tb_top.sv */
// Purpose: self-checking bench of the register bank
// Assumes: host model drives the bus
// Notes: integer model of registers and readings
`timescale 1ns/100ps
module tb_top;
	logic clk;
	logic rst_n;
	logic psel;
	logic pen;
	logic pwr;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [3:0] pstrb;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [10:0] lt;
	logic [10:0] rt;
	logic tv;
	logic am;
	logic [10:0] at;
	logic [7:0] dq;
	logic [7:0] duty;
	logic fstop;
	tdlr_pkg::tdlr_limits_t llim;
	tdlr_pkg::tdlr_limits_t rlim;
	logic [5:0] pbits;
	logic frz;
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [31:0] last_rd;
	logic last_er;
	logic [11:0] ta[13] = '{12'h018, 12'h028, 12'h02c, 12'h050, 12'h054, 12'h058, 12'h060, 12'h064, 12'h068,
		12'h06c, 12'h070, 12'h074, 12'h080};
	int exp_v[13] = '{0, 32'h80, 32'h80, 32'h3c, 0, 32'h46, 32'h50, 0, 32'h64, 32'h50, 0, 32'h69, 0};
	tdlr_top DUT (.I_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
		.I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
		.I_LOCAL_TEMP(lt), .I_REMOTE_TEMP(rt), .I_TEMP_VALID(tv), .I_AUTO_TEMP_MODE(am), .I_ACTIVE_TEMP(at),
		.I_DUTY_REQ(dq), .O_DUTY(duty), .O_FAN_STOPPED(fstop), .O_LOCAL_LIMITS(llim), .O_REMOTE_LIMITS(rlim),
		.O_PASSIVE_BITS(pbits), .O_READINGS_FROZEN(frz));
	tdlr_host host (.i_clk(clk), .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr), .o_psel(psel),
		.o_penable(pen), .o_pwrite(pwr), .o_paddr(paddr), .o_pwdata(pwdata), .o_pstrb(pstrb));
	// ----------------------------------------------------------------
	// clock, timeout and shared tasks
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// a hang in the bus wait ends here
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			results();
		end
	end
	task automatic results();
		if (err_total == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		cmp_count++;
		if (g !== x) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic xe);
		host.xfer(w, a, d, s, last_rd, last_er);
		chk("pslverr", {31'h0, xe}, {31'h0, last_er});
		if (xe) chk("error data", 32'h0, last_rd);
	endtask
	task automatic rdc(input string n, input logic [11:0] a, input int x);
		acc(1'b0, a, 32'h0, 4'h0, 1'b0);
		chk(n, x, last_rd);
	endtask
	// low byte read first, remote upper third, so readings never stay frozen
	task automatic check_all();
		for (int i = 0; i < 13; i++) begin
			rdc("register", ta[i], exp_v[i]);
		end
		chk("local limits", {exp_v[3][7:0], exp_v[4][7:0], exp_v[5][7:0], exp_v[9][7:0]}, llim);
		chk("remote limits", {exp_v[6][7:0], exp_v[7][7:0], exp_v[8][7:0], exp_v[11][7:0]}, rlim);
		chk("passive bits", exp_v[10], {26'h0, pbits});
	endtask
	task automatic temp(input int l, input int r);
		lt <= l[10:0];
		rt <= r[10:0];
		tv <= 1'b1;
		@(posedge clk);
		tv <= 1'b0;
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		int j, d, s, l, r, l2, r2, a, m, q;
		rst_n = 1'b0;
		tv = 1'b0;
		lt = 11'h000;
		rt = 11'h000;
		am = 1'b0;
		at = 11'h000;
		dq = 8'h00;
		void'($urandom(32'h402c));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		check_all();
		// random data and strobes over every register, read-only ones included
		for (int k = 0; k < 26; k++) begin
			j = k % 13;
			d = $urandom;
			s = $urandom;
			acc(1'b1, ta[j], d, s[3:0], 1'b0);
			if (j >= 3 && j < 12 && s[0]) exp_v[j] = d & (j == 10 ? 32'h3f : 32'hff);
		end
		check_all();
		acc(1'b0, 12'h084, 32'h0, 4'h0, 1'b1);
		acc(1'b1, 12'h052, 32'hff, 4'hf, 1'b1);
		acc(1'b0, 12'h450, 32'h0, 4'h0, 1'b1);
		rdc("no write on error", 12'h050, exp_v[3]);
		l = $urandom & 32'h7ff;
		r = $urandom & 32'h7ff;
		l2 = $urandom & 32'h7ff;
		r2 = $urandom & 32'h7ff;
		temp(l, r);
		rdc("remote upper", 12'h02c, r >> 3);
		rdc("local upper", 12'h028, l >> 3);
		rdc("low byte", 12'h018, ((l & 7) << 5) | (r & 7));
		chk("frozen flag", 32'h1, {31'h0, frz});
		temp(l2, r2);
		rdc("frozen local", 12'h028, l >> 3);
		rdc("frozen remote", 12'h02c, r >> 3);
		rdc("parked remote", 12'h02c, r2 >> 3);
		rdc("parked low", 12'h018, ((l2 & 7) << 5) | (r2 & 7));
		rdc("parked local", 12'h028, l2 >> 3);
		rdc("release", 12'h02c, r2 >> 3);
		chk("released flag", 32'h0, {31'h0, frz});
		// active temperature straddles the threshold, from 12 eighths below to 12 above
		for (int k = 0; k < 40; k++) begin
			a = exp_v[10] * 8 + $urandom_range(24) - 12;
			m = $urandom;
			q = $urandom;
			am <= m[0];
			at <= a[10:0];
			dq <= q[7:0];
			@(posedge clk);
			@(posedge clk);
			chk("duty", (m[0] && a <= exp_v[10] * 8) ? 32'h0 : q & 32'hff, {24'h0, duty});
			chk("fan stopped", (m[0] && a <= exp_v[10] * 8) ? 1 : 0, {31'h0, fstop});
		end
		results();
	end
endmodule
